// File: verilog/speed_ref_defines.svh
// constants for the speed reference select and pi speed controller
`ifndef SPEED_REF_DEFINES_SVH
`define SPEED_REF_DEFINES_SVH
// reference origin codes
`define ORIGIN_FOLLOW      2'h0
`define ORIGIN_REMOTE      2'h1
`define ORIGIN_LOCAL       2'h2
// control principle codes
`define PRINCIPLE_OPEN     2'h0
`define PRINCIPLE_CLOSED   2'h3
// error direction codes
`define DIR_NORMAL         1'h0
`define DIR_INVERSE        1'h1
// feedback source code that names analog input 54
`define FB_SRC_AIN54       8'h36
// integral time in seconds that switches the integrator off
`define INTEG_TIME_OFF_S   16'h2710
// sample tick period
`define SAMPLE_PERIOD_US   1000
`define CLK_MHZ            50
`define SAMPLE_CYCLES      (`SAMPLE_PERIOD_US * `CLK_MHZ)
// local reference step per arrow key press
`define LOCAL_STEP         16'h0010
`endif

// File: verilog/speed_ref_pkg.sv
// types for the speed reference select and pi speed controller
package speed_ref_pkg;
  typedef enum logic [1:0] {
    KEY_OFF_HAND,
    KEY_OFF_AUTO,
    KEY_HAND,
    KEY_AUTO
  } key_mode_t;
endpackage : speed_ref_pkg

// File: verilog/sample_tick.sv
// divider making a one-cycle sample tick for the controller
`timescale 1ns/100ps
`default_nettype none
module sample_tick #(
  parameter int unsigned CYCLES = 50000
) (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  output var  logic tick_o
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_tick;

  // count down and pulse on wrap
  always_comb
  begin
    next_tick  = 1'b0;
    next_count = count - 32'h0000_0001;
    if (count == 32'h0000_0000)
    begin
      next_count = 32'(CYCLES - 1);
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      count  <= 32'(CYCLES - 1);
      tick_o <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      tick_o <= next_tick;
    end
  end
endmodule : sample_tick
`default_nettype wire

// File: verilog/speed_reference_select_pid.sv
// key mode, reference selection and pi speed controller of the drive
`timescale 1ns/100ps
`default_nettype none
`include "speed_ref_defines.svh"

module speed_reference_select_pid
  import speed_ref_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        key_hand_i,
  input  wire logic        key_off_i,
  input  wire logic        key_auto_i,
  input  wire logic        key_reset_i,
  input  wire logic        key_up_i,
  input  wire logic        key_down_i,
  input  wire logic        en_hand_i,
  input  wire logic        en_off_i,
  input  wire logic        en_auto_i,
  input  wire logic        en_reset_i,
  input  wire logic [1:0]  origin_i,
  input  wire logic [1:0]  principle_i,
  input  wire logic        error_direction_select_i,
  input  wire logic [15:0] remote_ref_i,
  input  wire logic        remote_run_i,
  input  wire logic [15:0] feedback_i,
  input  wire logic        fb_src_load_i,
  input  wire logic [7:0]  fb_src_i,
  input  wire logic [15:0] prop_gain_i,
  input  wire logic [15:0] integ_time_i,
  input  wire logic [15:0] ramp_step_i,
  input  wire logic [15:0] min_speed_i,
  input  wire logic [15:0] max_speed_i,
  input  wire logic [15:0] max_freq_i,
  output var  logic        hand_mode_o,
  output var  logic        auto_mode_o,
  output var  logic        running_o,
  output var  logic        local_active_o,
  output var  logic        remote_active_o,
  output var  logic        closed_loop_o,
  output var  logic        alarm_clear_o,
  output var  logic [7:0]  fb_src_o,
  output var  logic [15:0] local_ref_o,
  output var  logic [15:0] speed_cmd_o
);
  // ************************************************************
  // key mode and local reference
  // ************************************************************
  key_mode_t   mode;
  key_mode_t   next_mode;
  logic [15:0] local_ref;
  logic [15:0] next_local_ref;
  logic        next_alarm_clear;
  logic [7:0]  fb_src;
  logic [7:0]  next_fb_src;
  logic [16:0] up_sum;

  // hand, off and auto keys each have their own enable
  always_comb
  begin
    next_mode        = mode;
    next_alarm_clear = key_reset_i && en_reset_i;
    next_fb_src      = fb_src_load_i ? fb_src_i : fb_src;
    up_sum           = {1'b0, local_ref} + {1'b0, `LOCAL_STEP};
    next_local_ref   = local_ref;
    if (key_hand_i && en_hand_i)
      next_mode = KEY_HAND;
    else if (key_auto_i && en_auto_i)
      next_mode = KEY_AUTO;
    else if (key_off_i && en_off_i)
    begin
      case (mode)
        KEY_HAND: next_mode = KEY_OFF_HAND;
        KEY_AUTO: next_mode = KEY_OFF_AUTO;
        default:  next_mode = mode;
      endcase
    end
    // arrows saturate at zero and full scale
    if (key_up_i && !key_down_i)
      next_local_ref = up_sum[16] ? 16'hFFFF : up_sum[15:0];
    else if (key_down_i && !key_up_i)
      next_local_ref = (local_ref < `LOCAL_STEP) ? 16'h0000 : local_ref - `LOCAL_STEP;
  end

  // reset leaves the drive off after auto, so the remote reference leads
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      mode          <= KEY_OFF_AUTO;
      local_ref     <= 16'h0000;
      alarm_clear_o <= 1'b0;
      fb_src        <= `FB_SRC_AIN54;
    end
    else
    begin
      mode          <= next_mode;
      local_ref     <= next_local_ref;
      alarm_clear_o <= next_alarm_clear;
      fb_src        <= next_fb_src;
    end
  end

  // ************************************************************
  // active reference selection
  // ************************************************************
  logic use_local;
  logic use_closed;
  logic run_req;

  // one select bit keeps the two references mutually exclusive
  always_comb
  begin
    case (origin_i)
      `ORIGIN_REMOTE: use_local = 1'b0;
      `ORIGIN_LOCAL:  use_local = 1'b1;
      default:        use_local = (mode == KEY_HAND) || (mode == KEY_OFF_HAND);
    endcase
    // closed loop only with remote reference active
    use_closed = !use_local && (principle_i == `PRINCIPLE_CLOSED);
    // hand always runs, auto runs only while the remote run request stands
    run_req = (mode == KEY_HAND) || ((mode == KEY_AUTO) && remote_run_i);
  end

  // ************************************************************
  // pi speed controller
  // ************************************************************
  logic        tick;
  logic signed [31:0] integ;
  logic signed [31:0] next_integ;
  logic signed [17:0] err;
  logic signed [35:0] p_term;
  logic signed [35:0] i_step;
  logic signed [37:0] integ_wide;
  logic signed [37:0] pi_sum;
  logic [15:0] pi_out;
  logic signed [31:0] lim_hi;
  logic        integ_on;

  sample_tick #(
    .CYCLES (`SAMPLE_CYCLES)
  ) u_tick (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .tick_o (tick)
  );

  // integral is error divided by integral time, held in speed units
  always_comb
  begin
    integ_on = (integ_time_i < `INTEG_TIME_OFF_S) && (integ_time_i != 16'h0000);
    if (error_direction_select_i == `DIR_NORMAL)
      err = $signed({2'b00, remote_ref_i}) - $signed({2'b00, feedback_i});
    else
      err = $signed({2'b00, feedback_i}) - $signed({2'b00, remote_ref_i});
    p_term = (err * $signed({2'b00, prop_gain_i})) >>> 8;
    i_step = integ_on ? 36'(err / $signed({2'b00, integ_time_i})) : 36'sd0;
    lim_hi = $signed({16'h0000, max_speed_i});
    integ_wide = 38'(integ) + 38'(i_step);
    next_integ = integ;
    if (!use_closed || !run_req || !integ_on)
      next_integ = 32'sd0;
    else if (tick)
    begin
      // saturate the accumulator so it cannot wind up past the limits
      if (integ_wide > 38'(lim_hi))
        next_integ = lim_hi;
      else if (integ_wide < 38'sd0)
        next_integ = 32'sd0;
      else
        next_integ = integ_wide[31:0];
    end
    // the integral reaches the speed only at the tick after it moves
    pi_sum = 38'(p_term) + 38'(integ);
    if (pi_sum < 38'sd0)
      pi_out = 16'h0000;
    else if (pi_sum > 38'sh0_0000_FFFF)
      pi_out = 16'hFFFF;
    else
      pi_out = pi_sum[15:0];
  end

  // accumulator register, emptied by reset
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      integ <= 32'sd0;
    else
      integ <= next_integ;
  end

  // ************************************************************
  // ramp, speed limit and frequency clamp
  // ************************************************************
  logic [15:0] target;
  logic [15:0] lim_target;
  logic [15:0] speed;
  logic [15:0] next_speed;
  logic [15:0] next_cmd;
  logic [16:0] ramp_up;

  // ramp moves once per sample tick so the slope does not depend on clock
  always_comb
  begin
    if (use_closed)
      target = pi_out;
    else
      target = use_local ? local_ref : remote_ref_i;
    lim_target = target;
    if (lim_target > max_speed_i)
      lim_target = max_speed_i;
    if (lim_target < min_speed_i)
      lim_target = min_speed_i;
    if (!run_req)
      lim_target = 16'h0000;
    ramp_up    = {1'b0, speed} + {1'b0, ramp_step_i};
    next_speed = speed;
    if (tick)
    begin
      if (speed < lim_target)
        next_speed = (ramp_up[15:0] > lim_target || ramp_up[16]) ? lim_target : ramp_up[15:0];
      else if (speed > lim_target)
        next_speed = (speed - lim_target < ramp_step_i) ? lim_target : speed - ramp_step_i;
    end
    // clamp after the ramp so a lowered frequency limit bites at the next clock edge
    next_cmd = (speed > max_freq_i) ? max_freq_i : speed;
  end

  // ramped speed and clamped command registers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      speed       <= 16'h0000;
      speed_cmd_o <= 16'h0000;
    end
    else
    begin
      speed       <= next_speed;
      speed_cmd_o <= next_cmd;
    end
  end

  // ************************************************************
  // registered status outputs
  // ************************************************************
  logic next_hand_mode;
  logic next_auto_mode;
  logic next_running;
  logic next_local_active;
  logic next_remote_active;
  logic next_closed_loop;

  // flags built here so the flops below only copy them
  always_comb
  begin
    next_hand_mode     = (next_mode == KEY_HAND);
    next_auto_mode     = (next_mode == KEY_AUTO);
    next_running       = run_req;
    next_local_active  = use_local;
    next_remote_active = !use_local;
    next_closed_loop   = use_closed;
  end

  // status flops, remote flag high in reset so one reference is always active
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      hand_mode_o     <= 1'b0;
      auto_mode_o     <= 1'b0;
      running_o       <= 1'b0;
      local_active_o  <= 1'b0;
      remote_active_o <= 1'b1;
      closed_loop_o   <= 1'b0;
      fb_src_o        <= `FB_SRC_AIN54;
      local_ref_o     <= 16'h0000;
    end
    else
    begin
      hand_mode_o     <= next_hand_mode;
      auto_mode_o     <= next_auto_mode;
      running_o       <= next_running;
      local_active_o  <= next_local_active;
      remote_active_o <= next_remote_active;
      closed_loop_o   <= next_closed_loop;
      fb_src_o        <= next_fb_src;
      local_ref_o     <= next_local_ref;
    end
  end
endmodule : speed_reference_select_pid
`default_nettype wire

// File: tb/speed_ref_sva.sv
// checker of key modes, reference choice and output limits
`timescale 1ns/100ps
`default_nettype none
`include "speed_ref_defines.svh"
module speed_ref_sva (
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic        key_hand_i,
  input wire logic        key_auto_i,
  input wire logic        key_reset_i,
  input wire logic        key_up_i,
  input wire logic        key_down_i,
  input wire logic        en_hand_i,
  input wire logic        en_off_i,
  input wire logic        en_auto_i,
  input wire logic        en_reset_i,
  input wire logic        fb_src_load_i,
  input wire logic        hand_mode_o,
  input wire logic        auto_mode_o,
  input wire logic        local_active_o,
  input wire logic        remote_active_o,
  input wire logic        alarm_clear_o,
  input wire logic [1:0]  origin_i,
  input wire logic [7:0]  fb_src_i,
  input wire logic [7:0]  fb_src_o,
  input wire logic [15:0] max_freq_i,
  input wire logic [15:0] local_ref_o,
  input wire logic [15:0] speed_cmd_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // two settled cycles of a mode, since the flags trail the mode by one edge
  sequence hand_follow_s;
    (hand_mode_o && origin_i == `ORIGIN_FOLLOW) [*2];
  endsequence
  sequence auto_follow_s;
    (auto_mode_o && origin_i == `ORIGIN_FOLLOW) [*2];
  endsequence
  hand_key_a: assert property (key_hand_i && en_hand_i |=> hand_mode_o && !auto_mode_o)
    else $error("hand key not taken");
  auto_key_a: assert property (key_auto_i && en_auto_i && !key_hand_i |=> auto_mode_o)
    else $error("auto key not taken");
  key_gate_a: assert property (!(en_hand_i || en_off_i || en_auto_i) |=> $stable(hand_mode_o))
    else $error("mode moved with keys disabled");
  alarm_set_a: assert property (key_reset_i && en_reset_i |=> alarm_clear_o)
    else $error("alarm clear missing");
  alarm_cause_a: assert property (alarm_clear_o |-> $past(key_reset_i) && $past(en_reset_i))
    else $error("alarm clear without press");
  origin_local_a: assert property ((origin_i == `ORIGIN_LOCAL) [*2] |-> local_active_o)
    else $error("local origin ignored");
  origin_remote_a: assert property ((origin_i == `ORIGIN_REMOTE) [*2] |-> remote_active_o)
    else $error("remote origin ignored");
  hand_local_a: assert property (hand_follow_s |-> local_active_o)
    else $error("hand mode not local");
  auto_remote_a: assert property (auto_follow_s |-> remote_active_o)
    else $error("auto mode not remote");
  one_ref_a: assert property (local_active_o != remote_active_o)
    else $error("reference flags not exclusive");
  fb_load_a: assert property (fb_src_load_i |=> fb_src_o == $past(fb_src_i))
    else $error("feedback source not loaded");
  fb_default_a: assert property ($fell(srst_i) |-> fb_src_o == `FB_SRC_AIN54)
    else $error("feedback source default wrong");
  local_step_a: assert property (hand_mode_o && key_up_i && !key_down_i
    && local_ref_o < 16'hFFF0 |=> local_ref_o == $past(local_ref_o) + `LOCAL_STEP)
    else $error("local reference step wrong");
  // the command trails the limit through one flop, so a new limit counts an edge later
  freq_clamp_a: assert property (speed_cmd_o <= $past(max_freq_i))
    else $error("speed above frequency limit");
endmodule : speed_ref_sva
bind speed_reference_select_pid speed_ref_sva chk (.*);
`default_nettype wire

// File: tb/sensor_model.sv
// feedback sensor model that reports motor speed
`timescale 1ns/100ps
`default_nettype none
module sensor_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] speed_i,
  input  wire logic [15:0] bias_i,
  output var  logic [15:0] feedback_o
);
  // sensor lags the shaft by a cycle; the bias stands for a process value
  // that sits apart from speed, so the bench can steer the error
  always_ff @(posedge mclk_i) feedback_o <= speed_i + bias_i;
endmodule : sensor_model
`default_nettype wire

// File: tb/test_speed_reference_select_pid.sv
// bench of key modes, reference choice and speed output
`timescale 1ns/100ps
`default_nettype none
`include "speed_ref_defines.svh"
module test_speed_reference_select_pid;
  // ****************
  // stimulus and harness
  // ****************
  logic mclk_i = 1'b0, srst_i = 1'b1, key_hand_i = 1'b0, key_off_i = 1'b0;
  logic key_auto_i = 1'b0, key_reset_i = 1'b0, key_up_i = 1'b0, key_down_i = 1'b0;
  logic en_hand_i = 1'b0, en_off_i = 1'b0, en_auto_i = 1'b0, en_reset_i = 1'b0;
  logic remote_run_i = 1'b0, fb_src_load_i = 1'b0, error_direction_select_i = 1'b0;
  logic [1:0]  origin_i = 2'h0, principle_i = 2'h0;
  logic [7:0]  fb_src_i = 8'h00;
  logic [15:0] remote_ref_i = 16'h0000, prop_gain_i = 16'h0100, integ_time_i = 16'h2710;
  logic [15:0] ramp_step_i = 16'hFFFF, min_speed_i = 16'h0000, max_speed_i = 16'hFFFF;
  logic [15:0] max_freq_i = 16'h0008;
  logic [15:0] fb_bias = 16'h0000;
  wire logic [15:0] feedback_i, local_ref_o, speed_cmd_o;
  wire logic [7:0]  fb_src_o;
  wire logic hand_mode_o, auto_mode_o, running_o, local_active_o, remote_active_o;
  wire logic closed_loop_o, alarm_clear_o;
  int bad_count = 0;
  int n_tests = 0;
  always #10 mclk_i = ~mclk_i;
  speed_reference_select_pid dut (.*);
  sensor_model feed (
    .mclk_i     (mclk_i),
    .speed_i    (speed_cmd_o),
    .bias_i     (fb_bias),
    .feedback_o (feedback_i)
  );
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc
  // one-cycle press: 0 hand, 1 off, 2 auto, 3 reset, 4 up, 5 down
  task press(input int k);
    {key_hand_i, key_off_i, key_auto_i, key_reset_i, key_up_i, key_down_i} = 6'h20 >> k;
    cyc(1);
    {key_hand_i, key_off_i, key_auto_i, key_reset_i, key_up_i, key_down_i} = 6'h00;
  endtask : press
  task wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ****************
  // scenarios
  // ****************
  task t_alarm;
    press(3);
    chk("alarm_off", alarm_clear_o, 16'h0000);
    en_reset_i = 1'b1;
    cyc(1);
    press(3);
    chk("alarm_on", alarm_clear_o, 16'h0001);
    cyc(1);
    chk("alarm_end", alarm_clear_o, 16'h0000);
    fb_src_i = 8'h12;
    fb_src_load_i = 1'b1;
    cyc(1);
    fb_src_load_i = 1'b0;
    chk("fb_src", fb_src_o, 16'h0012);
  endtask : t_alarm
  task t_hand;
    press(0);
    chk("hand_refused", hand_mode_o, 16'h0000);
    en_hand_i = 1'b1;
    cyc(1);
    press(0);
    chk("hand", hand_mode_o, 16'h0001);
    cyc(1);
    chk("hand_local", local_active_o, 16'h0001);
    chk("running", running_o, 16'h0001);
    origin_i = `ORIGIN_REMOTE;
    cyc(2);
    chk("forced_remote", remote_active_o, 16'h0001);
    origin_i = `ORIGIN_FOLLOW;
    en_off_i = 1'b1;
    press(1);
    chk("off", hand_mode_o, 16'h0000);
    cyc(1);
    chk("off_local", local_active_o, 16'h0001);
  endtask : t_hand
  task t_auto;
    en_auto_i = 1'b1;
    remote_run_i = 1'b1;
    remote_ref_i = 16'h0100;
    error_direction_select_i = `DIR_INVERSE;
    press(2);
    chk("auto", auto_mode_o, 16'h0001);
    cyc(2);
    chk("auto_remote", remote_active_o, 16'h0001);
    chk("open_loop", closed_loop_o, 16'h0000);
    principle_i = `PRINCIPLE_CLOSED;
    cyc(2);
    chk("closed_loop", closed_loop_o, 16'h0001);
    origin_i = `ORIGIN_LOCAL;
    cyc(2);
    chk("forced_local", local_active_o, 16'h0001);
    chk("local_open", closed_loop_o, 16'h0000);
  endtask : t_auto
  task t_speed;
    origin_i = `ORIGIN_FOLLOW;
    principle_i = `PRINCIPLE_OPEN;
    remote_run_i = 1'b0;
    max_speed_i = 16'h0FFF;
    press(0);
    cyc(1);
    press(4);
    cyc(1);
    press(4);
    cyc(1);
    press(5);
    chk("local_ref", local_ref_o, `LOCAL_STEP);
  endtask : t_speed
  // inverse error 0x0300 - 0x0100 at gain 2.0 asks for 0x0400 at the tick
  task t_pid;
    remote_ref_i = 16'h0100;
    prop_gain_i = 16'h0200;
    fb_bias = 16'h0300;
    max_freq_i = 16'h0800;
    principle_i = `PRINCIPLE_CLOSED;
    remote_run_i = 1'b1;
    error_direction_select_i = `DIR_INVERSE;
    cyc(1);
    press(2);
    cyc(2);
    chk("pid_loop", closed_loop_o, 16'h0001);
    chk("pid_idle", speed_cmd_o, 16'h0000);
    // the tick period is fixed, so the first tick is waited out
    cyc(50100);
    chk("pid_out", speed_cmd_o, 16'h0400);
    max_freq_i = 16'h0008;
    cyc(1);
    chk("speed_clamp", speed_cmd_o, 16'h0008);
  endtask : t_pid
  initial
  begin
    cyc(4);
    srst_i = 1'b0;
    chk("reset_remote", remote_active_o, 16'h0001);
    chk("reset_fb_src", fb_src_o, 16'h0036);
    t_alarm;
    t_hand;
    t_auto;
    t_speed;
    t_pid;
    wrap_up;
  end
  // hang guard sized a little past the one long tick wait
  initial
  begin
    repeat (55000) @(posedge mclk_i);
    bad_count++;
    wrap_up;
  end
endmodule : test_speed_reference_select_pid
`default_nettype wire
